/* File: rtl/iscr_consts.vh */
// Constants for the image sensor control register bank
// How it works
// - Sequencer bit 0 picks double-sampled or nondestructive readout.
// - Sequencer bits 1-2 pick nondestructive variant; ignored when bit 0 clear.
// - Sequencer bit 3 resets pixels before readout.
// - Sequencer bit 4: shutter when clear, two-sided row addressing when set.
// - Sequencer bits 5 and 6 set frame and line calibration speed.
// - Sequencer bit 7 enables continuous column precharge.
// - Sequencer bits 9:8 form column sequencer clock granularity.
// - Sequencer bit 10 disconnects column amplifiers, output at dark level.
// - Sequencer bit 11 holds all pixels in continuous reset.
// - Pixel count is 11 bits, column pairs per row, at most 1111.
// - Line count is 12 bits, rows per frame, at most 3014.
// - Pulse delay bits 3:0 delay valid pulse, bits 7:4 end pulses.
// - Column start 7 bits 0..98, row start 8 bits 0..137.
// - Image core: test mode 1:0, column subsample 4:2, row subsample 7:5.
// - Amplifier gain from bits 3:0 unless bit 4 forces unity gain.
// - Amplifier bit 5 multiplexes both streams onto first output.
// - Amplifier bit 6 standby; bits 9:7 amplifier clock delay.
// - Three 8-bit offset registers reset to mid-scale 0x80.
// - Converter bit 2 stops multiplexing; bit 3 delays or switches converters.
// - Converter bit 4 picks outside clock; bit 5 tristates digital outputs.
// - Converter bits 8:6 clock delay, bit 9 gamma, bit 10 bit flip.
// - All registers load through the three-wire serial port.
// - Each row delivers twice pixel count plus two pixels.
`ifndef ISCR_CONSTS_VH
`define ISCR_CONSTS_VH

// Register indices
`define ISCR_SEQ_CTRL     4'h0
`define ISCR_PIX_COUNT    4'h1
`define ISCR_LINE_COUNT   4'h2
`define ISCR_INT_TIME     4'h3
`define ISCR_PULSE_DELAY  4'h4
`define ISCR_COL_START    4'h5
`define ISCR_ROW_START    4'h6
`define ISCR_IMAGE_CORE   4'h7
`define ISCR_AMP_CFG      4'h8
`define ISCR_OFS_COARSE   4'h9
`define ISCR_OFS_FINE     4'hA
`define ISCR_DARK_REF     4'hB
`define ISCR_CONV_CFG     4'hC
`define ISCR_NUM_REGS     13

// Reset values
`define ISCR_SEQ_CTRL_RST    12'h100
`define ISCR_PIX_COUNT_RST   12'h200
`define ISCR_LINE_COUNT_RST  12'hBC6
`define ISCR_INT_TIME_RST    12'h001
`define ISCR_PULSE_DELAY_RST 12'h003
`define ISCR_MID_SCALE_RST   12'h080
`define ISCR_AMP_CFG_RST     12'h010
`define ISCR_ZERO_RST        12'h000

// Register widths as masks
`define ISCR_MASK_12 12'hFFF
`define ISCR_MASK_11 12'h7FF
`define ISCR_MASK_10 12'h3FF
`define ISCR_MASK_8  12'h0FF
`define ISCR_MASK_7  12'h07F

// Range limits
`define ISCR_PIX_COUNT_MAX  12'h457
`define ISCR_LINE_COUNT_MAX 12'hBC6
`define ISCR_COL_START_MAX  12'h062
`define ISCR_ROW_START_MAX  12'h089

// Serial frame: 4-bit index then 12-bit data, first bit is MSB
`define ISCR_FRAME_BITS 16
`define ISCR_ADDR_MSB   15
`define ISCR_ADDR_LSB   12

`endif

/* File: rtl/iscr_regs.v */
// Image sensor control register bank with serial load port
`timescale 1ns/1ns
`include "iscr_consts.vh"

module iscr_regs (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rstn_in,
  // Three-wire serial load port
  input  wire        ser_clock_in,
  input  wire        ser_data_in,
  input  wire        ser_load_in,
  // Sequencer controls
  output reg         nondestructive_readout_enable_out,
  output reg  [1:0]  nondestructive_variant_out,
  output reg         reset_before_read_out,
  output reg         two_sided_rows_out,
  output reg         frame_cal_slow_out,
  output reg         line_cal_slow_out,
  output reg         continuous_column_precharge_out,
  output reg  [1:0]  column_clock_gran_out,
  output reg         dark_level_out,
  output reg         reset_all_pixels_out,
  // Window and timing
  output reg  [10:0] pixel_count_limit_out,
  output reg  [11:0] pixels_per_row_out,
  output reg  [11:0] line_count_limit_out,
  output reg  [11:0] integration_time_out,
  output reg  [3:0]  valid_pulse_delay_out,
  output reg  [3:0]  end_pulse_delay_out,
  output reg  [6:0]  column_start_out,
  output reg  [7:0]  row_start_out,
  // Image core
  output reg  [1:0]  test_mode_out,
  output reg  [2:0]  column_subsample_out,
  output reg  [2:0]  row_subsample_out,
  // Output amplifier
  output reg  [3:0]  amp_gain_out,
  output reg         amp_unity_out,
  output reg         amp_single_out_out,
  output reg         amp_standby_out,
  output reg  [2:0]  amp_clock_delay_out,
  output reg  [7:0]  amp_offset_coarse_out,
  output reg  [7:0]  amp_offset_fine_out,
  output reg  [7:0]  dark_reference_level_out,
  // Converter
  output reg  [1:0]  converter_standby_out,
  output reg         converter_mux_off_out,
  output reg         converter_switch_out,
  output reg         outside_converter_clock_out,
  output reg         output_tristate_out,
  output reg  [2:0]  converter_clock_delay_out,
  output reg         gamma_enable_out,
  output reg         output_bit_flip_out
);

////////////////////////////////////////////////////////////////////////////
// Reset value and width per register index

function [11:0] iscr_reset_value;
  input integer idx;
  begin
    case (idx)
      `ISCR_SEQ_CTRL:    iscr_reset_value = `ISCR_SEQ_CTRL_RST;
      `ISCR_PIX_COUNT:   iscr_reset_value = `ISCR_PIX_COUNT_RST;
      `ISCR_LINE_COUNT:  iscr_reset_value = `ISCR_LINE_COUNT_RST;
      `ISCR_INT_TIME:    iscr_reset_value = `ISCR_INT_TIME_RST;
      `ISCR_PULSE_DELAY: iscr_reset_value = `ISCR_PULSE_DELAY_RST;
      `ISCR_AMP_CFG:     iscr_reset_value = `ISCR_AMP_CFG_RST;
      `ISCR_OFS_COARSE,
      `ISCR_OFS_FINE,
      `ISCR_DARK_REF:    iscr_reset_value = `ISCR_MID_SCALE_RST;
      default:           iscr_reset_value = `ISCR_ZERO_RST;
    endcase
  end
endfunction

function [11:0] iscr_mask;
  input integer idx;
  begin
    case (idx)
      `ISCR_SEQ_CTRL,
      `ISCR_LINE_COUNT,
      `ISCR_INT_TIME:   iscr_mask = `ISCR_MASK_12;
      `ISCR_PIX_COUNT,
      `ISCR_CONV_CFG:   iscr_mask = `ISCR_MASK_11;
      `ISCR_AMP_CFG:    iscr_mask = `ISCR_MASK_10;
      `ISCR_COL_START:  iscr_mask = `ISCR_MASK_7;
      default:          iscr_mask = `ISCR_MASK_8;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Serial port: shift on serial clock rise, commit on load rise

reg  [15:0] shift_word;
reg         ser_clock_prev;
reg         ser_load_prev;
wire        ser_clock_rise = ser_clock_in & ~ser_clock_prev;
wire        ser_load_rise  = ser_load_in & ~ser_load_prev;
wire [3:0]  wr_index = shift_word[`ISCR_ADDR_MSB:`ISCR_ADDR_LSB];
wire [11:0] wr_raw   = shift_word[11:0];

// Shift register and edge history
always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    shift_word     <= 16'h0000;
    ser_clock_prev <= 1'b0;
    ser_load_prev  <= 1'b0;
  end else begin
    ser_clock_prev <= ser_clock_in;
    ser_load_prev  <= ser_load_in;
    if (ser_clock_rise) begin
      shift_word <= {shift_word[14:0], ser_data_in};
    end
  end
end

// Clamp range-limited fields to their largest legal value
reg [11:0] wr_value;
always @* begin
  wr_value = wr_raw;
  case (wr_index)
    `ISCR_PIX_COUNT: begin
      if ((wr_raw & `ISCR_MASK_11) > `ISCR_PIX_COUNT_MAX) begin
        wr_value = `ISCR_PIX_COUNT_MAX;
      end
    end
    `ISCR_LINE_COUNT: begin
      if (wr_raw > `ISCR_LINE_COUNT_MAX) begin
        wr_value = `ISCR_LINE_COUNT_MAX;
      end
    end
    `ISCR_COL_START: begin
      if ((wr_raw & `ISCR_MASK_7) > `ISCR_COL_START_MAX) begin
        wr_value = `ISCR_COL_START_MAX;
      end
    end
    `ISCR_ROW_START: begin
      if ((wr_raw & `ISCR_MASK_8) > `ISCR_ROW_START_MAX) begin
        wr_value = `ISCR_ROW_START_MAX;
      end
    end
    default: wr_value = wr_raw;
  endcase
end

////////////////////////////////////////////////////////////////////////////
// Register storage, one entry per index

reg [11:0] bank [0:`ISCR_NUM_REGS-1];

genvar gi;
generate
  for (gi = 0; gi < `ISCR_NUM_REGS; gi = gi + 1) begin : g_entry
    // Reset to default; reserved indices never match
    always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        bank[gi] <= iscr_reset_value(gi);
      end else if (ser_load_rise && wr_index == gi) begin
        bank[gi] <= wr_value & iscr_mask(gi);
      end
    end
  end
endgenerate

wire [11:0] seq  = bank[`ISCR_SEQ_CTRL];
wire [11:0] amp  = bank[`ISCR_AMP_CFG];
wire [11:0] conv = bank[`ISCR_CONV_CFG];
wire [11:0] dly  = bank[`ISCR_PULSE_DELAY];
wire [11:0] core = bank[`ISCR_IMAGE_CORE];
wire [11:0] pixc = bank[`ISCR_PIX_COUNT];
wire [11:0] row_total = {pixc[10:0], 1'b0} + 12'h002;

////////////////////////////////////////////////////////////////////////////
// Next values of the decoded outputs

// Sequencer fields
reg         next_nondestructive_readout_enable;
reg  [1:0]  next_nondestructive_variant;
reg         next_reset_before_read;
reg         next_two_sided_rows;
reg         next_frame_cal_slow;
reg         next_line_cal_slow;
reg         next_continuous_column_precharge;
reg  [1:0]  next_column_clock_gran;
reg         next_dark_level;
reg         next_reset_all_pixels;
// Window and timing fields
reg  [10:0] next_pixel_count_limit;
reg  [11:0] next_pixels_per_row;
reg  [11:0] next_line_count_limit;
reg  [11:0] next_integration_time;
reg  [3:0]  next_valid_pulse_delay;
reg  [3:0]  next_end_pulse_delay;
reg  [6:0]  next_column_start;
reg  [7:0]  next_row_start;
// Image core fields
reg  [1:0]  next_test_mode;
reg  [2:0]  next_column_subsample;
reg  [2:0]  next_row_subsample;
// Output amplifier fields
reg  [3:0]  next_amp_gain;
reg         next_amp_unity;
reg         next_amp_single_out;
reg         next_amp_standby;
reg  [2:0]  next_amp_clock_delay;
reg  [7:0]  next_amp_offset_coarse;
reg  [7:0]  next_amp_offset_fine;
reg  [7:0]  next_dark_reference_level;
// Converter fields
reg  [1:0]  next_converter_standby;
reg         next_converter_mux_off;
reg         next_converter_switch;
reg         next_outside_converter_clock;
reg         next_output_tristate;
reg  [2:0]  next_converter_clock_delay;
reg         next_gamma_enable;
reg         next_output_bit_flip;

// Field decode from the bank, one line per output
always @* begin
  // Sequencer
  next_nondestructive_readout_enable = seq[0];
  // Variant only matters during nondestructive readout
  next_nondestructive_variant = seq[0] ? seq[2:1] : 2'h0;
  next_reset_before_read           = seq[3];
  next_two_sided_rows              = seq[4];
  next_frame_cal_slow              = seq[5];
  next_line_cal_slow               = seq[6];
  next_continuous_column_precharge = seq[7];
  next_column_clock_gran           = seq[9:8];
  next_dark_level                  = seq[10];
  next_reset_all_pixels            = seq[11];

  // Window and timing
  next_pixel_count_limit = pixc[10:0];
  next_pixels_per_row    = row_total;
  next_line_count_limit  = bank[`ISCR_LINE_COUNT];
  next_integration_time  = bank[`ISCR_INT_TIME];
  next_valid_pulse_delay = dly[3:0];
  next_end_pulse_delay   = dly[7:4];
  next_column_start      = bank[`ISCR_COL_START][6:0];
  next_row_start         = bank[`ISCR_ROW_START][7:0];

  // Image core
  next_test_mode        = core[1:0];
  next_column_subsample = core[4:2];
  next_row_subsample    = core[7:5];

  // Output amplifier; unity forces the gain setting out of use
  next_amp_gain             = amp[4] ? 4'h0 : amp[3:0];
  next_amp_unity            = amp[4];
  next_amp_single_out       = amp[5];
  next_amp_standby          = amp[6];
  next_amp_clock_delay      = amp[9:7];
  next_amp_offset_coarse    = bank[`ISCR_OFS_COARSE][7:0];
  next_amp_offset_fine      = bank[`ISCR_OFS_FINE][7:0];
  next_dark_reference_level = bank[`ISCR_DARK_REF][7:0];

  // Converter
  next_converter_standby       = conv[1:0];
  next_converter_mux_off       = conv[2];
  next_converter_switch        = conv[3];
  next_outside_converter_clock = conv[4];
  next_output_tristate         = conv[5];
  next_converter_clock_delay   = conv[8:6];
  next_gamma_enable            = conv[9];
  next_output_bit_flip         = conv[10];
end

////////////////////////////////////////////////////////////////////////////
// Decoded control outputs, registered

// Sequencer outputs
always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    nondestructive_readout_enable_out <= 1'b0;
    nondestructive_variant_out        <= 2'h0;
    reset_before_read_out             <= 1'b0;
    two_sided_rows_out                <= 1'b0;
    frame_cal_slow_out                <= 1'b0;
    line_cal_slow_out                 <= 1'b0;
    continuous_column_precharge_out   <= 1'b0;
    column_clock_gran_out             <= 2'h1;
    dark_level_out                    <= 1'b0;
    reset_all_pixels_out              <= 1'b0;
  end else begin
    nondestructive_readout_enable_out <= next_nondestructive_readout_enable;
    nondestructive_variant_out        <= next_nondestructive_variant;
    reset_before_read_out             <= next_reset_before_read;
    two_sided_rows_out                <= next_two_sided_rows;
    frame_cal_slow_out                <= next_frame_cal_slow;
    line_cal_slow_out                 <= next_line_cal_slow;
    continuous_column_precharge_out   <= next_continuous_column_precharge;
    column_clock_gran_out             <= next_column_clock_gran;
    dark_level_out                    <= next_dark_level;
    reset_all_pixels_out              <= next_reset_all_pixels;
  end
end

// Window and timing outputs
always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    pixel_count_limit_out <= 11'h200;
    pixels_per_row_out    <= 12'h402;
    line_count_limit_out  <= 12'hBC6;
    integration_time_out  <= 12'h001;
    valid_pulse_delay_out <= 4'h3;
    end_pulse_delay_out   <= 4'h0;
    column_start_out      <= 7'h00;
    row_start_out         <= 8'h00;
  end else begin
    pixel_count_limit_out <= next_pixel_count_limit;
    pixels_per_row_out    <= next_pixels_per_row;
    line_count_limit_out  <= next_line_count_limit;
    integration_time_out  <= next_integration_time;
    valid_pulse_delay_out <= next_valid_pulse_delay;
    end_pulse_delay_out   <= next_end_pulse_delay;
    column_start_out      <= next_column_start;
    row_start_out         <= next_row_start;
  end
end

// Image core outputs
always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    test_mode_out        <= 2'h0;
    column_subsample_out <= 3'h0;
    row_subsample_out    <= 3'h0;
  end else begin
    test_mode_out        <= next_test_mode;
    column_subsample_out <= next_column_subsample;
    row_subsample_out    <= next_row_subsample;
  end
end

// Output amplifier outputs
always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    amp_gain_out             <= 4'h0;
    amp_unity_out            <= 1'b1;
    amp_single_out_out       <= 1'b0;
    amp_standby_out          <= 1'b0;
    amp_clock_delay_out      <= 3'h0;
    amp_offset_coarse_out    <= 8'h80;
    amp_offset_fine_out      <= 8'h80;
    dark_reference_level_out <= 8'h80;
  end else begin
    amp_gain_out             <= next_amp_gain;
    amp_unity_out            <= next_amp_unity;
    amp_single_out_out       <= next_amp_single_out;
    amp_standby_out          <= next_amp_standby;
    amp_clock_delay_out      <= next_amp_clock_delay;
    amp_offset_coarse_out    <= next_amp_offset_coarse;
    amp_offset_fine_out      <= next_amp_offset_fine;
    dark_reference_level_out <= next_dark_reference_level;
  end
end

// Converter outputs
always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    converter_standby_out       <= 2'h0;
    converter_mux_off_out       <= 1'b0;
    converter_switch_out        <= 1'b0;
    outside_converter_clock_out <= 1'b0;
    output_tristate_out         <= 1'b0;
    converter_clock_delay_out   <= 3'h0;
    gamma_enable_out            <= 1'b0;
    output_bit_flip_out         <= 1'b0;
  end else begin
    converter_standby_out       <= next_converter_standby;
    converter_mux_off_out       <= next_converter_mux_off;
    converter_switch_out        <= next_converter_switch;
    outside_converter_clock_out <= next_outside_converter_clock;
    output_tristate_out         <= next_output_tristate;
    converter_clock_delay_out   <= next_converter_clock_delay;
    gamma_enable_out            <= next_gamma_enable;
    output_bit_flip_out         <= next_output_bit_flip;
  end
end

endmodule

/* File: test/iscr_checker.sv */
// Concurrent checks on the register bank outputs
`timescale 1ns/1ns
module iscr_checker (
  // Clock and reset
  input wire        clk_in,
  input wire        rstn_in,
  // Load strobe
  input wire        ser_load_in,
  // Watched outputs
  input wire        nondestructive_readout_enable_out,
  input wire [1:0]  nondestructive_variant_out,
  input wire [1:0]  column_clock_gran_out,
  input wire [10:0] pixel_count_limit_out,
  input wire [11:0] pixels_per_row_out,
  input wire [11:0] line_count_limit_out,
  input wire [6:0]  column_start_out,
  input wire [7:0]  row_start_out,
  input wire [3:0]  amp_gain_out,
  input wire        amp_unity_out,
  input wire [7:0]  amp_offset_coarse_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  property p_variant;
    !nondestructive_readout_enable_out |-> nondestructive_variant_out == 2'h0;
  endproperty
  a_variant: assert property (p_variant)
    else $error("variant shown while disabled");
  property p_row_len;
    pixels_per_row_out == {pixel_count_limit_out, 1'b0} + 12'h002;
  endproperty
  a_row_len: assert property (p_row_len)
    else $error("pixels per row mismatch");
  property p_pix_max; pixel_count_limit_out <= 11'h457; endproperty
  a_pix_max: assert property (p_pix_max)
    else $error("pixel count above limit");
  property p_line_max; line_count_limit_out <= 12'hBC6; endproperty
  a_line_max: assert property (p_line_max)
    else $error("line count above limit");
  property p_start_max;
    column_start_out <= 7'h62 && row_start_out <= 8'h89;
  endproperty
  a_start_max: assert property (p_start_max)
    else $error("start position above limit");
  property p_unity; amp_unity_out |-> amp_gain_out == 4'h0; endproperty
  a_unity: assert property (p_unity)
    else $error("gain not zero under unity");
  property p_defaults;
    $rose(rstn_in) |-> column_clock_gran_out == 2'h1 && amp_unity_out
      && line_count_limit_out == 12'hBC6 && amp_offset_coarse_out == 8'h80;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("defaults missing after reset");
  property p_hold;
    $changed({line_count_limit_out, row_start_out})
      |-> $past(ser_load_in) || $past(ser_load_in, 2);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed without a load");
endmodule
bind iscr_regs iscr_checker iscr_checker_inst (.*);

/* File: test/iscr_ctrl_model.sv */
// Camera controller model driving the three-wire serial load port
`timescale 1ns/1ns
module iscr_ctrl_model (
  // Clock
  input  wire clk_in,
  // Serial load port
  output reg  ser_clock_out,
  output reg  ser_data_out,
  output reg  ser_load_out
);
  integer i;
  initial begin
    ser_clock_out = 1'b0;
    ser_data_out  = 1'b0;
    ser_load_out  = 1'b0;
  end
  // Index then data, first bit out is bit 15; each level lasts gap cycles
  task send(input [3:0] idx, input [11:0] val, input integer gap);
    reg [15:0] frame;
    begin
      frame = {idx, val};
      for (i = 15; i >= 0; i = i - 1) begin
        @(negedge clk_in);
        ser_data_out  = frame[i];
        ser_clock_out = 1'b1;
        repeat (gap) @(negedge clk_in);
        ser_clock_out = 1'b0;
        repeat (gap - 1) @(negedge clk_in);
      end
      @(negedge clk_in);
      ser_load_out = 1'b1;
      repeat (2) @(negedge clk_in);
      ser_load_out = 1'b0;
      ser_data_out = ~ser_data_out;
    end
  endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the register bank
`timescale 1ns/1ns
module tb;
  reg clk_in;
  reg rstn_in;
  integer bad_count;
  integer n_compared;
  integer b;
  wire ser_clock_in, ser_data_in, ser_load_in;
  wire nondestructive_readout_enable_out, reset_before_read_out;
  wire two_sided_rows_out, frame_cal_slow_out, line_cal_slow_out;
  wire continuous_column_precharge_out, dark_level_out;
  wire reset_all_pixels_out, amp_unity_out, amp_single_out_out;
  wire amp_standby_out, converter_mux_off_out, converter_switch_out;
  wire outside_converter_clock_out, output_tristate_out;
  wire gamma_enable_out, output_bit_flip_out;
  wire [1:0] nondestructive_variant_out, column_clock_gran_out;
  wire [1:0] test_mode_out, converter_standby_out;
  wire [2:0] column_subsample_out, row_subsample_out, amp_clock_delay_out;
  wire [2:0] converter_clock_delay_out;
  wire [3:0] valid_pulse_delay_out, end_pulse_delay_out, amp_gain_out;
  wire [6:0] column_start_out;
  wire [7:0] row_start_out, amp_offset_coarse_out, amp_offset_fine_out;
  wire [7:0] dark_reference_level_out;
  wire [10:0] pixel_count_limit_out;
  wire [11:0] pixels_per_row_out, line_count_limit_out, integration_time_out;
  // Output fields gathered back into register order
  wire [11:0] seq_v = {reset_all_pixels_out, dark_level_out,
    column_clock_gran_out, continuous_column_precharge_out, line_cal_slow_out,
    frame_cal_slow_out, two_sided_rows_out, reset_before_read_out,
    nondestructive_variant_out, nondestructive_readout_enable_out};
  wire [9:0] amp_v = {amp_clock_delay_out, amp_standby_out,
    amp_single_out_out, amp_unity_out, amp_gain_out};
  wire [10:0] conv_v = {output_bit_flip_out, gamma_enable_out,
    converter_clock_delay_out, output_tristate_out,
    outside_converter_clock_out, converter_switch_out, converter_mux_off_out,
    converter_standby_out};
  wire [7:0] core_v = {row_subsample_out, column_subsample_out, test_mode_out};
  wire [7:0] dly_v = {end_pulse_delay_out, valid_pulse_delay_out};
  iscr_regs iscr_regs_inst (.*);
  iscr_ctrl_model iscr_ctrl_model_inst (.clk_in(clk_in),
    .ser_clock_out(ser_clock_in), .ser_data_out(ser_data_in),
    .ser_load_out(ser_load_in));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task chk(input [11:0] got, input [11:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] idx, input [11:0] val);
    begin
      iscr_ctrl_model_inst.send(idx, val, 1);
      repeat (3) @(negedge clk_in);
    end
  endtask
  task defaults_test;
    begin
      chk(seq_v, 12'h100);
      chk(pixels_per_row_out, 12'h402);
      chk(line_count_limit_out, 12'hBC6);
      chk(integration_time_out, 12'h001);
      chk(dly_v, 12'h003);
      chk(column_start_out, 12'h000);
      chk(row_start_out, 12'h000);
      chk(core_v, 12'h000);
      chk(amp_v, 12'h010);
      chk(amp_offset_coarse_out, 12'h080);
      chk(amp_offset_fine_out, 12'h080);
      chk(dark_reference_level_out, 12'h080);
      chk(conv_v, 12'h000);
      chk(pixel_count_limit_out, 12'h200);
    end
  endtask
  task seq_test;
    begin
      for (b = 0; b < 12; b = b + 1) begin
        wr(4'h0, 12'h001 << b);
        chk(seq_v, (b == 1 || b == 2) ? 12'h000 : 12'h001 << b);
      end
      wr(4'h0, 12'hFFE);
      chk(seq_v, 12'hFF8);
      chk(reset_before_read_out, 12'h001);
      chk(two_sided_rows_out, 12'h001);
      chk({line_cal_slow_out, frame_cal_slow_out}, 12'h003);
      chk(continuous_column_precharge_out, 12'h001);
      chk(column_clock_gran_out, 12'h003);
      chk(dark_level_out, 12'h001);
      chk(reset_all_pixels_out, 12'h001);
      wr(4'h0, 12'h007);
      chk(seq_v, 12'h007);
    end
  endtask
  task range_test;
    begin
      wr(4'h1, 12'h457);
      chk(pixels_per_row_out, 12'h8B0);
      chk(pixel_count_limit_out, 12'h457);
      wr(4'h1, 12'h7FF);
      chk(pixel_count_limit_out, 12'h457);
      wr(4'h2, 12'h5DC);
      chk(line_count_limit_out, 12'h5DC);
      wr(4'h2, 12'hFFF);
      chk(line_count_limit_out, 12'hBC6);
      wr(4'h5, 12'h07F);
      chk(column_start_out, 12'h062);
      wr(4'h6, 12'h0FF);
      chk(row_start_out, 12'h089);
    end
  endtask
  task field_test;
    begin
      wr(4'h4, 12'h0A5);
      chk(dly_v, 12'h0A5);
      wr(4'h7, 12'h0B6);
      chk(core_v, 12'h0B6);
      wr(4'h8, 12'h3EF);
      chk(amp_v, 12'h3EF);
      chk(amp_single_out_out, 12'h001);
      wr(4'h8, 12'h01A);
      chk(amp_v, 12'h010);
      iscr_ctrl_model_inst.send(4'hA, 12'h034, 3);
      repeat (3) @(negedge clk_in);
      chk(amp_offset_fine_out, 12'h034);
      wr(4'hC, 12'h5A5);
      chk(conv_v, 12'h5A5);
      chk(converter_standby_out, 12'h001);
      chk(converter_clock_delay_out, 12'h006);
      chk(output_bit_flip_out, 12'h001);
      wr(4'hC, 12'h2DA);
      chk(conv_v, 12'h2DA);
      chk(converter_standby_out, 12'h002);
      chk(gamma_enable_out, 12'h001);
      wr(4'h3, 12'hA5C);
      chk(integration_time_out, 12'hA5C);
      wr(4'h9, 12'h0C3);
      chk(amp_offset_coarse_out, 12'h0C3);
      wr(4'hB, 12'h13C);
      chk(dark_reference_level_out, 12'h03C);
    end
  endtask
  task reserved_test;
    begin
      for (b = 13; b < 16; b = b + 1) wr(b[3:0], 12'hFFF);
      chk(conv_v, 12'h2DA);
      chk({dly_v, row_start_out[3:0]}, 12'hA59);
      chk(seq_v, 12'h007);
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Hang guard
  initial begin
    repeat (40000) @(posedge clk_in);
    bad_count = bad_count + 1;
    test_done;
  end
  // Main sequence
  initial begin
    bad_count = 0;
    n_compared = 0;
    rstn_in = 1'b0;
    repeat (5) @(negedge clk_in);
    rstn_in = 1'b1;
    @(negedge clk_in);
    defaults_test;
    seq_test;
    range_test;
    field_test;
    reserved_test;
    rstn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    @(negedge clk_in);
    defaults_test;
    test_done;
  end
endmodule
